// >>> rtl/dds_rx_status.v
// dds_rx_status.v: receive rails, loss of signal, activation sequencer,
// loopback steering and serial line status for a DDS line transceiver
// assumes: line inputs are sliced comparator levels from the analog front
// end; level and step indications come from the equalizer's detectors
`timescale 1ns/100ps
`default_nettype none
`include "dds_rx_regs.vh"

// How it works
// R1 - positive pulse on the line sets the positive receive rail
// R2 - negative pulse on the line sets the negative receive rail
// R3 - rails change once per bit, stable at the recovered clock falling edge
// R4 - more than 32 consecutive zero symbols raise loss of signal
// R5 - loss of signal restarts the activation sequence by itself
// R6 - after true loss, flag stays high 0.13 s to 16 s after energy returns
// R7 - on a large strength drop, flag stays high 0.26 s to 16 s
// R8 - recovered clock free-runs through long zero runs; far end limits zeros
// R9 - bipolar violations pass to the rails untouched
// R10 - loopback sends recovered data and clock to transmit and still outputs them
// R11 - in loopback the transmit rail and clock inputs are ignored
// R12 - status word shifts out while the enable is held low for eight bits
// R13 - status word: loop length b3..b0, state b6..b4, loss flag b7
// R14 - filter search alternates state code 100 and 000
// R15 - convergence reports 001, full operation reports 010
// R16 - search starts at code 0111, steps down in gain while level too high
// R17 - nine filter codes 0111 to 1111 drive the equalizer
// R18 - slow amplitude drift and impulses do not disturb reception
// R19 - large sustained steps re-initialise; small steps adapt in the analog path
// R20 - outside logic watches violations and resets after a bad step
// R21 - rate is fixed; a far-end rate change is not detected
// R22 - recovered clock is a divided clock pulled toward received pulses
// R23 - outside logic resets after rate, loopback or line changes
// R24 - status bits leave b0 first, one per bit period
module dds_rx_status #(
  parameter [31:0] LOS_LOSS_MIN_CYC = `DDS_LOS_LOSS_MIN_MS * `DDS_CLK_KHZ,
  parameter [31:0] LOS_DROP_MIN_CYC = `DDS_LOS_DROP_MIN_MS * `DDS_CLK_KHZ,
  parameter [31:0] LOS_MAX_CYC = `DDS_LOS_MAX_MS * `DDS_CLK_KHZ,
  parameter [31:0] OFFSET_CYC = `DDS_OFFSET_MS * `DDS_CLK_KHZ,
  parameter [31:0] LEVEL_CYC = `DDS_LEVEL_MS * `DDS_CLK_KHZ,
  parameter [31:0] CONV_CYC = `DDS_CONV_MS * `DDS_CLK_KHZ
) (
  // clock, reset, enable
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // line receive comparators
  input wire rx_line_plus_in,
  input wire rx_line_minus_in,
  // equalizer detectors
  input wire level_exceeds_in,
  input wire strength_step_in,
  // control pins
  input wire loopback_select_in,
  input wire status_shift_enable_n_in,
  // transmit pins
  input wire tx_positive_rail_in,
  input wire tx_negative_rail_in,
  input wire transmit_clock_in,
  // receive outputs
  output reg rx_positive_rail_out,
  output reg rx_negative_rail_out,
  output wire rx_clock_out,
  output reg loss_of_signal_flag_out,
  output wire line_status_word_out,
  // transmit path toward line encoder
  output reg line_tx_positive_out,
  output reg line_tx_negative_out,
  output reg line_tx_clock_out,
  // equalizer control
  output reg [3:0] filter_select_out,
  output reg offset_cancel_out
);

  localparam [1:0] ST_OFFSET = 2'd0;
  localparam [1:0] ST_LEVEL = 2'd1;
  localparam [1:0] ST_CONV = 2'd2;
  localparam [1:0] ST_FULL = 2'd3;

  localparam integer NSYNC = 9;
  localparam integer I_PLUS = 0;
  localparam integer I_MINUS = 1;
  localparam integer I_LEVEL = 2;
  localparam integer I_STEP = 3;
  localparam integer I_LOOPBACK_SELECT = 4;
  localparam integer I_LSEN = 5;
  localparam integer I_TXP = 6;
  localparam integer I_TXN = 7;
  localparam integer I_TXC = 8;

  // state code for the status word, b6..b4
  function [2:0] state_code;
    input [1:0] st;
    begin
      case (st)
        ST_OFFSET: state_code = `DDS_ST_CODE_OFFSET;
        ST_LEVEL: state_code = `DDS_ST_CODE_LEVEL;
        ST_CONV: state_code = `DDS_ST_CODE_CONV;
        ST_FULL: state_code = `DDS_ST_CODE_FULL;
        default: state_code = `DDS_ST_CODE_LEVEL;
      endcase
    end
  endfunction

  wire [NSYNC-1:0] pin_raw;
  reg [NSYNC-1:0] sync_a_reg;
  reg [NSYNC-1:0] sync_b_reg;
  reg [NSYNC-1:0] sync_c_reg;
  reg [NSYNC-1:0] pin_reg;

  reg mark_d_reg;
  reg pos_cap_reg;
  reg neg_cap_reg;
  reg [6:0] zero_cnt_reg;
  reg true_loss_reg;
  reg [31:0] hold_cnt_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] ll_reg;
  reg [3:0] ll_next;
  reg [31:0] dwell_reg;
  reg [11:0] step_cnt_reg;

  wire sample_tick;
  wire bit_tick;
  wire rclk;
  wire mark_now;
  wire mark_edge;
  wire sym_mark;
  wire los_trig;
  wire step_reinit;
  wire [31:0] hold_min;
  wire los_release;
  wire [7:0] status_word;
  reg [31:0] dwell_limit;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once the 2nd and 3rd stages agree
  assign pin_raw = {transmit_clock_in, tx_negative_rail_in, tx_positive_rail_in,
                    status_shift_enable_n_in, loopback_select_in, strength_step_in,
                    level_exceeds_in, rx_line_minus_in, rx_line_plus_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge clk_in) begin
        if (rst_in) begin
          sync_a_reg[gi] <= (gi == I_LSEN) ? 1'b1 : 1'b0;
          sync_b_reg[gi] <= (gi == I_LSEN) ? 1'b1 : 1'b0;
          sync_c_reg[gi] <= (gi == I_LSEN) ? 1'b1 : 1'b0;
          pin_reg[gi] <= (gi == I_LSEN) ? 1'b1 : 1'b0;
        end else if (ce_in) begin
          sync_a_reg[gi] <= pin_raw[gi];
          sync_b_reg[gi] <= sync_a_reg[gi];
          sync_c_reg[gi] <= sync_b_reg[gi];
          if (sync_b_reg[gi] == sync_c_reg[gi])
            pin_reg[gi] <= sync_c_reg[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // clock recovery and data extraction
  assign mark_now = pin_reg[I_PLUS] ^ pin_reg[I_MINUS];
  assign mark_edge = ce_in & mark_now & ~mark_d_reg;

  dds_dpll u_dpll (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .mark_edge_in(mark_edge),
    .sample_tick_out(sample_tick),
    .bit_tick_out(bit_tick),
    .rx_clock_out(rclk)
  );

  assign rx_clock_out = rclk; // R22

  // no polarity check on marks, so violations reach the rails as received
  always @(posedge clk_in) begin
    if (rst_in) begin
      mark_d_reg <= 1'b0;
      pos_cap_reg <= 1'b0;
      neg_cap_reg <= 1'b0;
      rx_positive_rail_out <= 1'b0;
      rx_negative_rail_out <= 1'b0;
    end else if (ce_in) begin
      mark_d_reg <= mark_now;
      if (sample_tick) begin
        pos_cap_reg <= pin_reg[I_PLUS] & ~pin_reg[I_MINUS]; // R1
        neg_cap_reg <= pin_reg[I_MINUS] & ~pin_reg[I_PLUS]; // R2
      end
      if (bit_tick) begin
        rx_positive_rail_out <= pos_cap_reg; // R3 R9
        rx_negative_rail_out <= neg_cap_reg; // R3 R9
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // zero-run counter and loss-of-signal flag
  assign sym_mark = pin_reg[I_PLUS] | pin_reg[I_MINUS];
  assign los_trig = sample_tick & ~sym_mark & (zero_cnt_reg == `DDS_LOS_ZEROS); // R4
  assign hold_min = true_loss_reg ? LOS_LOSS_MIN_CYC : LOS_DROP_MIN_CYC;
  assign los_release = loss_of_signal_flag_out &
                       (((state_reg == ST_FULL) && (hold_cnt_reg >= hold_min)) ||
                        (hold_cnt_reg >= LOS_MAX_CYC)); // R6 R7

  always @(posedge clk_in) begin
    if (rst_in) begin
      zero_cnt_reg <= 7'h00;
      true_loss_reg <= 1'b0;
      hold_cnt_reg <= 32'h0000_0000;
      loss_of_signal_flag_out <= 1'b0;
    end else if (ce_in) begin
      if (sample_tick) begin
        if (sym_mark)
          zero_cnt_reg <= 7'h00;
        else if (zero_cnt_reg != `DDS_ZERO_SAT)
          zero_cnt_reg <= zero_cnt_reg + 7'h01;
      end
      if (los_trig) begin
        loss_of_signal_flag_out <= 1'b1; // R4
      end else if (los_release) begin
        loss_of_signal_flag_out <= 1'b0; // R6 R7
      end
      // true loss: hold time counts only once energy is back
      if (!loss_of_signal_flag_out || los_release) begin
        hold_cnt_reg <= 32'h0000_0000;
        true_loss_reg <= 1'b0;
      end else if (zero_cnt_reg >= `DDS_TRUE_LOSS_ZEROS) begin
        true_loss_reg <= 1'b1; // R6
        hold_cnt_reg <= 32'h0000_0000; // R6
      end else if (zero_cnt_reg <= `DDS_LOS_ZEROS || !true_loss_reg) begin
        hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001; // R7
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // step detector: a short burst is taken as impulse noise and dropped
  assign step_reinit = (step_cnt_reg == `DDS_STEP_REJECT); // R18 R19

  always @(posedge clk_in) begin
    if (rst_in) begin
      step_cnt_reg <= 12'h000;
    end else if (ce_in) begin
      if (!pin_reg[I_STEP] || state_reg != ST_FULL)
        step_cnt_reg <= 12'h000; // R18
      else if (!step_reinit)
        step_cnt_reg <= step_cnt_reg + 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // activation sequencer; line rate is fixed, no rate search is done
  always @* begin
    case (state_reg)
      ST_OFFSET: dwell_limit = OFFSET_CYC;
      ST_LEVEL: dwell_limit = LEVEL_CYC;
      ST_CONV: dwell_limit = CONV_CYC;
      default: dwell_limit = 32'h0000_0000;
    endcase
  end

  always @* begin
    state_next = state_reg;
    ll_next = ll_reg;
    if (los_trig || (step_reinit && pin_reg[I_STEP])) begin
      state_next = ST_OFFSET; // R5 R19
      ll_next = `DDS_LL_FIRST; // R16
    end else if (state_reg != ST_FULL && dwell_reg >= dwell_limit) begin
      case (state_reg)
        ST_OFFSET: state_next = ST_LEVEL; // R14
        ST_LEVEL: begin
          if (pin_reg[I_LEVEL] && ll_reg != `DDS_LL_LAST) begin
            ll_next = ll_reg + 4'h1; // R16 R17
            state_next = ST_OFFSET; // R14
          end else begin
            state_next = ST_CONV; // R15
          end
        end
        ST_CONV: state_next = ST_FULL; // R15
        default: state_next = ST_OFFSET;
      endcase
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= ST_OFFSET;
      ll_reg <= `DDS_LL_FIRST;
      dwell_reg <= 32'h0000_0000;
      filter_select_out <= `DDS_LL_FIRST;
      offset_cancel_out <= 1'b1;
    end else if (ce_in) begin
      state_reg <= state_next;
      ll_reg <= ll_next;
      filter_select_out <= ll_next; // R17
      offset_cancel_out <= (state_next == ST_OFFSET); // R14
      if (state_next != state_reg || los_trig)
        dwell_reg <= 32'h0000_0000;
      else if (state_reg != ST_FULL)
        dwell_reg <= dwell_reg + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // loopback steering toward the transmit encoder
  always @(posedge clk_in) begin
    if (rst_in) begin
      line_tx_positive_out <= 1'b0;
      line_tx_negative_out <= 1'b0;
      line_tx_clock_out <= 1'b0;
    end else if (ce_in) begin
      if (pin_reg[I_LOOPBACK_SELECT]) begin
        line_tx_positive_out <= rx_positive_rail_out; // R10 R11
        line_tx_negative_out <= rx_negative_rail_out; // R10 R11
        line_tx_clock_out <= rclk; // R10 R11
      end else begin
        line_tx_positive_out <= pin_reg[I_TXP];
        line_tx_negative_out <= pin_reg[I_TXN];
        line_tx_clock_out <= pin_reg[I_TXC];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // line status word and its serial port
  assign status_word = {loss_of_signal_flag_out, state_code(state_reg), ll_reg}; // R13

  dds_status_shift u_shift (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .word_in(status_word),
    .enable_n_in(pin_reg[I_LSEN]),
    .bit_tick_in(bit_tick),
    .serial_out(line_status_word_out)
  );

endmodule
`default_nettype wire

// >>> rtl/dds_rx_regs.vh
// dds_rx_regs.vh: constants for the switched-56 receive status logic
// assumes: 200 MHz core clock, one fixed line rate of 56 kbit/s
`ifndef DDS_RX_REGS_VH
`define DDS_RX_REGS_VH

// core clock, kHz, so that ms * kHz gives cycles
`define DDS_CLK_KHZ 32'd200000

// bit period at 56 kbit/s: 200 MHz / 56 kHz = 3571.4, rounded down
`define DDS_BIT_DIV 12'd3571
`define DDS_LAST_PH 12'd3570
`define DDS_HALF_PH 12'd1785
`define DDS_SAMPLE_PH 12'd892

// zero-run thresholds, in symbols
`define DDS_LOS_ZEROS 7'd32
`define DDS_TRUE_LOSS_ZEROS 7'd64
`define DDS_ZERO_SAT 7'h7F

// loss-of-signal hold times, ms
`define DDS_LOS_LOSS_MIN_MS 32'd130
`define DDS_LOS_DROP_MIN_MS 32'd260
`define DDS_LOS_MAX_MS 32'd16000

// activation dwell times, ms
`define DDS_OFFSET_MS 32'd20
`define DDS_LEVEL_MS 32'd20
`define DDS_CONV_MS 32'd200

// step indication must persist this long, cycles
`define DDS_STEP_REJECT 12'd2048

// status word layout
`define DDS_LS_LL_LSB 0
`define DDS_LS_ST_LSB 4
`define DDS_LS_LOS_BIT 7
`define DDS_LS_BITS 4'd8

// loop length codes
`define DDS_LL_FIRST 4'h7
`define DDS_LL_LAST 4'hF

// activation state codes, b6..b4
`define DDS_ST_CODE_OFFSET 3'h4
`define DDS_ST_CODE_LEVEL 3'h0
`define DDS_ST_CODE_CONV 3'h1
`define DDS_ST_CODE_FULL 3'h2

`endif

// >>> rtl/dds_dpll.v
// dds_dpll.v: bit-rate phase accumulator that recovers the line clock
// assumes: mark_edge_in is a one-cycle pulse from synchronised line inputs
`timescale 1ns/100ps
`default_nettype none
`include "dds_rx_regs.vh"

module dds_dpll (
  // clock and control
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // line events
  input wire mark_edge_in,
  // recovered timing
  output wire sample_tick_out,
  output wire bit_tick_out,
  output reg rx_clock_out
);

  reg [11:0] phase_reg;
  reg [11:0] phase_next;

  //////////////////////////////////////////////////////////////////////////
  // nudge by one step per mark; free-runs through long zero runs
  always @* begin
    phase_next = phase_reg + 12'h001;
    if (mark_edge_in) begin
      if (phase_reg > `DDS_HALF_PH)
        phase_next = phase_reg + 12'h002; // R22
      else if (phase_reg != 12'h000)
        phase_next = phase_reg; // R22
    end
    if (phase_next >= `DDS_BIT_DIV)
      phase_next = phase_next - `DDS_BIT_DIV; // R8 R21
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      phase_reg <= 12'h000;
      rx_clock_out <= 1'b0;
    end else if (ce_in) begin
      phase_reg <= phase_next;
      rx_clock_out <= (phase_next < `DDS_HALF_PH); // R22
    end
  end

  assign sample_tick_out = ce_in & (phase_reg == `DDS_SAMPLE_PH);
  assign bit_tick_out = ce_in & (phase_reg == `DDS_LAST_PH);

endmodule
`default_nettype wire

// >>> rtl/dds_status_shift.v
// dds_status_shift.v: serial shifter for the 8-bit line status word
// assumes: enable_n_in is already synchronised, bit_tick_in once per bit
`timescale 1ns/100ps
`default_nettype none
`include "dds_rx_regs.vh"

module dds_status_shift (
  // clock and control
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // word and timing
  input wire [7:0] word_in,
  input wire enable_n_in,
  input wire bit_tick_in,
  // serial output
  output reg serial_out
);

  reg enable_d_reg;
  reg [7:0] shift_reg;
  reg [3:0] left_reg;

  //////////////////////////////////////////////////////////////////////////
  // word is frozen at the falling enable so bits stay coherent
  always @(posedge clk_in) begin
    if (rst_in) begin
      enable_d_reg <= 1'b1;
      shift_reg <= 8'h00;
      left_reg <= 4'h0;
      serial_out <= 1'b0;
    end else if (ce_in) begin
      enable_d_reg <= enable_n_in;
      if (enable_n_in) begin
        left_reg <= 4'h0;
        serial_out <= 1'b0;
      end else if (enable_d_reg) begin
        shift_reg <= word_in; // R12
        left_reg <= `DDS_LS_BITS - 4'h1;
        serial_out <= word_in[0]; // R24
      end else if (bit_tick_in && left_reg != 4'h0) begin
        shift_reg <= {1'b0, shift_reg[7:1]}; // R24
        serial_out <= shift_reg[1]; // R24
        left_reg <= left_reg - 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> dv/dds_rx_status_properties.sv
// dds_rx_status_properties.sv: temporal checks on the receive status block
// assumes: bound into dds_rx_status; defaults match the bench's shortened counts
`timescale 1ns/100ps
`default_nettype none
module dds_rx_status_properties #(
  parameter [31:0] OFFSET_CYC = 32'h32,
  parameter [31:0] LOS_LOSS_MIN_CYC = 32'h7D0,
  parameter [31:0] LOS_MAX_CYC = 32'hBEBC_2000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // control pins
  input wire logic loopback_select_in,
  input wire logic status_shift_enable_n_in,
  // outputs
  input wire logic rx_positive_rail_out,
  input wire logic rx_negative_rail_out,
  input wire logic rx_clock_out,
  input wire logic loss_of_signal_flag_out,
  input wire logic line_status_word_out,
  input wire logic line_tx_positive_out,
  input wire logic line_tx_negative_out,
  input wire logic line_tx_clock_out,
  input wire logic [3:0] filter_select_out,
  input wire logic offset_cancel_out
);
  logic rclk_q;
  logic [6:0] quiet_bits;
  logic [11:0] hi_cnt;
  logic [31:0] los_cnt, off_cnt;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////
  // run lengths; quiet count saturates so long silences cannot wrap
  // counters hold with the design while the clock enable is low
  always_ff @(posedge clk_in) begin
    if (rst_in || ce_in) begin
      rclk_q <= rx_clock_out;
      hi_cnt <= (rx_clock_out && !rst_in) ? hi_cnt + 12'h001 : 12'h000;
      los_cnt <= (loss_of_signal_flag_out && !rst_in) ? los_cnt + 32'h1 : 32'h0;
      off_cnt <= (offset_cancel_out && !rst_in) ? off_cnt + 32'h1 : 32'h0;
      if (rst_in || rx_positive_rail_out || rx_negative_rail_out) begin
        quiet_bits <= 7'h00;
      end else if (rx_clock_out && !rclk_q && quiet_bits != 7'h7F) begin
        quiet_bits <= quiet_bits + 7'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  rails_exclusive_a: assert property (!(rx_positive_rail_out && rx_negative_rail_out))
    else $error("both rails high");
  rail_timing_a: assert property ($changed({rx_positive_rail_out, rx_negative_rail_out})
    |-> $rose(rx_clock_out)) else $error("rails moved off bit edge");
  clock_high_a: assert property ($fell(rx_clock_out)
    |-> hi_cnt >= 12'h6F4 && hi_cnt <= 12'h6FE) else $error("recovered clock high time");
  los_quiet_a: assert property ($rose(loss_of_signal_flag_out) |-> quiet_bits >= 7'h20)
    else $error("loss flag too early");
  los_restart_a: assert property ($rose(loss_of_signal_flag_out)
    |-> offset_cancel_out && filter_select_out == 4'h7) else $error("no restart on loss");
  los_hold_a: assert property ($fell(loss_of_signal_flag_out)
    |-> los_cnt >= LOS_LOSS_MIN_CYC && los_cnt <= LOS_MAX_CYC + 32'h1) else $error("loss hold");
  loop_data_a: assert property (loopback_select_in [*8] |=>
    line_tx_positive_out == $past(rx_positive_rail_out) &&
    line_tx_negative_out == $past(rx_negative_rail_out)) else $error("loopback data");
  loop_clock_a: assert property (loopback_select_in [*8]
    |=> line_tx_clock_out == $past(rx_clock_out)) else $error("loopback clock");
  status_idle_a: assert property (status_shift_enable_n_in [*8] |-> !line_status_word_out)
    else $error("status out while disabled");
  filter_step_a: assert property ($changed(filter_select_out) |-> offset_cancel_out &&
    (filter_select_out == $past(filter_select_out) + 4'h1 || filter_select_out == 4'h7))
    else $error("bad filter step");
  offset_dwell_a: assert property ($fell(offset_cancel_out) |-> off_cnt >= OFFSET_CYC)
    else $error("offset dwell short");
  filter_range_a: assert property (filter_select_out >= 4'h7)
    else $error("filter code out of range");
endmodule
bind dds_rx_status dds_rx_status_properties u_props (
  .clk_in, .rst_in, .ce_in, .loopback_select_in, .status_shift_enable_n_in,
  .rx_positive_rail_out, .rx_negative_rail_out, .rx_clock_out,
  .loss_of_signal_flag_out, .line_status_word_out, .line_tx_positive_out,
  .line_tx_negative_out, .line_tx_clock_out, .filter_select_out, .offset_cancel_out
);
`default_nettype wire

// >>> dv/dds_far_end.sv
// dds_far_end.sv: far-end line transmitter sending 50% AMI symbols
// assumes: already locked, so each symbol starts at a recovered clock rise
`timescale 1ns/100ps
`default_nettype none
module dds_far_end (
  // timing
  input wire logic clk_in,
  input wire logic rclk_in,
  // sliced line comparators, low between pulses
  output logic plus_out,
  output logic minus_out
);
  initial begin
    plus_out = 1'b0;
    minus_out = 1'b0;
  end
  // sym 2'h2 positive mark, 2'h1 negative mark, 2'h0 space
  // caller keeps zero runs short and alternates violations
  task automatic send(input logic [1:0] sym);
    @(posedge rclk_in);
    #1;
    plus_out = sym[1];
    minus_out = sym[0];
    repeat (1785) @(posedge clk_in);
    #1;
    plus_out = 1'b0;
    minus_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_dds_rx_status.sv
// tb_dds_rx_status.sv: directed tests of the receive status block
// assumes: dds_far_end drives the line, checker bound to the design
`timescale 1ns/100ps
`default_nettype none
module tb_dds_rx_status;
  logic clk_in = 1'b0, rst_in = 1'b1, lvl = 1'b0, step = 1'b0, loopback_select = 1'b0;
  logic sen_n = 1'b1, txp = 1'b0, txn = 1'b0, txc = 1'b0, coll = 1'b0, ce = 1'b1;
  wire lp, lm, rx_positive_rail, rx_negative_rail, rclk, los, lsw, ltp, ltn, ltc, offc;
  wire [3:0] fsel;
  int error_cnt = 0;
  int total_checks = 0;
  logic [1:0] rx_q[$];
  logic [7:0] w;
  logic [1:0] pat [0:9] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2, 2'h1};
  always #2.5 clk_in = ~clk_in;
  // short dwell and hold counts keep the run near a million ns
  dds_rx_status #(
    .LOS_LOSS_MIN_CYC(32'h7D0), .LOS_DROP_MIN_CYC(32'hFA0),
    .OFFSET_CYC(32'h32), .LEVEL_CYC(32'h32), .CONV_CYC(32'hC8)
  ) dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
    .rx_line_plus_in(lp), .rx_line_minus_in(lm),
    .level_exceeds_in(lvl), .strength_step_in(step),
    .loopback_select_in(loopback_select), .status_shift_enable_n_in(sen_n),
    .tx_positive_rail_in(txp), .tx_negative_rail_in(txn), .transmit_clock_in(txc),
    .rx_positive_rail_out(rx_positive_rail), .rx_negative_rail_out(rx_negative_rail), .rx_clock_out(rclk),
    .loss_of_signal_flag_out(los), .line_status_word_out(lsw),
    .line_tx_positive_out(ltp), .line_tx_negative_out(ltn), .line_tx_clock_out(ltc),
    .filter_select_out(fsel), .offset_cancel_out(offc)
  );
  dds_far_end far (.clk_in(clk_in), .rclk_in(rclk), .plus_out(lp), .minus_out(lm));
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_test(input string name);
    $display("test %s done, mismatches %0d", name, error_cnt);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // enable low for eight whole bits; bits read at recovered clock falls
  task automatic read_status(output logic [7:0] word);
    @(posedge rclk);
    #1;
    sen_n = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(negedge rclk);
      #1;
      word[i] = lsw;
    end
    @(posedge rclk);
    #1;
    sen_n = 1'b1;
  endtask
  always @(negedge rclk) begin
    #1;
    if (coll) rx_q.push_back({rx_positive_rail, rx_negative_rail});
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test;
  end
  initial begin
    int hit;
    int m;
    tick(5);
    rst_in = 1'b0;
    check({offc, fsel}, 8'h17, "reset code");
    check({los, rx_positive_rail, rx_negative_rail, lsw, ltp, ltn, ltc}, 8'h00, "reset outputs");
    end_test("reset");
    lvl = 1'b1;
    for (int i = 0; i < 2000 && fsel !== 4'h9; i++) tick(1);
    lvl = 1'b0;
    check(fsel, 8'h09, "search code");
    tick(600);
    check(offc, 8'h00, "settled");
    end_test("search");
    loopback_select = 1'b1;
    coll = 1'b1;
    foreach (pat[i]) begin
      txp = ~txp;
      txn = ~txn;
      txc = ~txc;
      far.send(pat[i]);
    end
    repeat (3) @(posedge rclk);
    #1;
    coll = 1'b0;
    hit = 0;
    for (int s = 0; s + 10 <= rx_q.size(); s++) begin
      m = 1;
      for (int j = 0; j < 10; j++) if (rx_q[s + j] !== pat[j]) m = 0;
      if (m == 1) hit = 1;
    end
    check(hit[7:0], 8'h01, "rail pattern");
    end_test("rails");
    loopback_select = 1'b0;
    txp = 1'b1;
    txn = 1'b1;
    txc = 1'b0;
    tick(10);
    check({ltp, ltn, ltc}, 8'h06, "tx pins");
    end_test("loopback");
    read_status(w);
    check(w, 8'h29, "status word");
    end_test("status");
    step = 1'b1;
    tick(1000);
    step = 1'b0;
    tick(20);
    check({offc, fsel}, 8'h09, "short step");
    step = 1'b1;
    tick(2080);
    step = 1'b0;
    check({offc, los, fsel}, 8'h27, "large step");
    ce = 1'b0;
    tick(200);
    check({offc, los, fsel}, 8'h27, "frozen offset");
    ce = 1'b1;
    tick(40);
    check({offc, fsel}, 8'h07, "offset resumed");
    rst_in = 1'b1;
    tick(5);
    rst_in = 1'b0;
    check({offc, los, fsel}, 8'h27, "reset again");
    end_test("step");
    far.send(2'h2);
    repeat (32) @(posedge rclk);
    tick(930);
    check({los, offc}, 8'h00, "32 zeros");
    @(posedge rclk);
    tick(930);
    check({los, offc, fsel}, 8'h37, "33 zeros");
    far.send(2'h2);
    far.send(2'h1);
    far.send(2'h2);
    tick(10);
    check({los, offc}, 8'h00, "energy back");
    end_test("loss");
    finish_test;
  end
endmodule
`default_nettype wire
